// *** hw/extended_framed_fifo_port.sv ***
// framed byte pipe between a usb byte fifo chip and peripheral logic
// assumes i_clock is the interface clock and all pins are asynchronous
// Summary of operation
// - extended reads need the internal enable register
// - busy leads first strobe, falls after last
// - request rising edge starts continuous read, busy
// - busy and subaddress two clocks after request
// - first read fetches count, bus by select
// - then N reads, first strobe marked, forwarded
// - 44 clocks count-to-data, 10 clocks tail
// - busy drops once all bytes are sent
// - host frames win over extended requests
// - extended frame: header, N-1, 0xff, data, trailer
// - eight bit count, at most 256 bytes
// - subaddress 0x7f shown during extended read
// - interrupts wait until the extended cycle ends
// - interrupt frame: zero count, direction 0
// - error status: bit 0 header, bit 1 trailer
// - user status read at 0x7f without busy
// - subaddress at two, status read at twenty
// - subaddress 0x7e reads the version byte
// - low reset pulse clears the whole device
// - user interrupt caught on its rising edge
// - read byte latched at end of strobe
// - hold input stretches the current strobe
`timescale 1ns/1ps
module extended_framed_fifo_port import efp_pkg::*; #(
   // arbitrary value, set per build
   parameter logic [7:0] INTERFACE_VERSION_BYTE = 8'h10
) (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_rx_empty_n,
   input wire logic i_tx_full_n,
   input wire logic [7:0] i_usb_data,
   output logic [7:0] o_usb_data,
   output logic o_usb_data_oe,
   output logic o_usb_read_n,
   output logic o_usb_write,
   input wire logic [7:0] i_user_data,
   output logic [7:0] o_user_data,
   output logic o_user_data_oe,
   output logic [6:0] o_subadd,
   output logic o_write_n,
   output logic o_read_n,
   output logic o_frame_first_strobe_n,
   input wire logic i_peripheral_hold_low,
   input wire logic i_extended_read_request,
   input wire logic i_user_interrupt,
   input wire logic i_shared_bus_select,
   output logic o_busy,
   output logic o_frame_start_fault,
   output logic o_frame_end_fault
);
   // ==========================================================
   // pin synchronisers
   logic rxe_n_s, txf_n_s, hold_s, req_s, uint_s, shared_s;
   logic [7:0] usb_s, user_s;

   pin_sync #(.WIDTH(SYNC_WIDTH)) u_sync (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_async({i_rx_empty_n, i_tx_full_n, i_usb_data, i_user_data,
                i_peripheral_hold_low, i_extended_read_request,
                i_user_interrupt, i_shared_bus_select}),
      .o_sync({rxe_n_s, txf_n_s, usb_s, user_s, hold_s, req_s, uint_s,
               shared_s})
   );

   // ==========================================================
   // peripheral strobe engine
   strobe_if sif();
   state_type state_q;
   kind_type kind_q;
   logic [7:0] count_q, idx_q, data_q, err_status_q;
   logic [6:0] sub_q;
   logic [5:0] wait_q;
   logic is_rd_q, busy_q, ext_enable_q, str_pend_q;
   logic ext_pend_q, int_pend_q, err_pend_q, req_prev_q, uint_prev_q;
   logic start_fault_q, end_fault_q;
   logic [1:0] end_cnt_q;
   logic str_need, ext_first_gate, is_ver, fifo_need, fifo_done;
   logic [7:0] tx_byte;

   periph_strobe u_strobe (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_hold_low(hold_s),
      .i_shared(shared_s),
      .i_data(shared_s ? usb_s : user_s),
      .o_write_n(o_write_n),
      .o_read_n(o_read_n),
      .o_frame_first_strobe_n(o_frame_first_strobe_n),
      .o_user_data(o_user_data),
      .o_user_data_oe(o_user_data_oe),
      .eng(sif)
   );

   assign is_ver = (kind_q == KIND_REPLY) &&
                   (sub_q == OFS_INTERFACE_VERSION_BYTE);
   // first extended data strobe waits for the count-to-data gap
   assign ext_first_gate = (kind_q != KIND_EXT) || (idx_q != 8'h00) ||
                           (wait_q >= 6'(EXT_GAP_CYCLES - 1));
   always_comb begin
      case (state_q)
         ST_PER_WR: str_need = !is_ver;
         ST_PER_RD: str_need = !is_ver && ext_first_gate;
         ST_EXT_CNT: str_need = 1'b1;
         ST_INT_RD: str_need = 1'b1;
         default: str_need = 1'b0;
      endcase
   end
   assign sif.start = str_need && !str_pend_q;
   assign sif.is_read = (state_q != ST_PER_WR);
   assign sif.first = (state_q == ST_PER_WR || state_q == ST_PER_RD) &&
                      idx_q == 8'h00;
   assign sif.wdata = data_q;

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         str_pend_q <= 1'b0;
      end else if (sif.start) begin
         str_pend_q <= 1'b1;
      end else if (sif.done) begin
         str_pend_q <= 1'b0;
      end
   end

   // ==========================================================
   // fifo chip byte engine
   logic fifo_pend_q, fifo_act_q, fifo_rd_q, fifo_quiet;
   logic [2:0] fifo_cnt_q;

   always_comb begin
      case (state_q)
         ST_RX_HDR, ST_RX_C1, ST_RX_C2, ST_RX_DATA, ST_RX_TRL,
         ST_TX_HDR, ST_TX_C1, ST_TX_C2, ST_TX_DATA, ST_TX_TRL:
            fifo_need = 1'b1;
         default: fifo_need = 1'b0;
      endcase
      case (state_q)
         ST_TX_HDR: tx_byte = HEADER_BYTE;
         ST_TX_C1: tx_byte = (kind_q == KIND_REPLY || kind_q == KIND_EXT) ?
                             count_q : 8'h00;
         ST_TX_C2: tx_byte = (kind_q == KIND_REPLY) ? {1'b1, sub_q} :
                             (kind_q == KIND_EXT) ? {1'b1, SUB_INTERRUPT} :
                             (kind_q == KIND_ERR) ? {1'b0, sub_q} :
                             {1'b0, SUB_INTERRUPT};
         ST_TX_DATA: tx_byte = data_q;
         default: tx_byte = TRAILER_BYTE;
      endcase
   end
   assign fifo_done = fifo_pend_q && fifo_act_q && (fifo_cnt_q ==
      (fifo_rd_q ? 3'(FIFO_RD_CYCLES - 1) : 3'(FIFO_WR_CYCLES - 1)));
   // the empty flag is stale for a few clocks after a byte is popped
   assign fifo_quiet = !fifo_pend_q && fifo_cnt_q == 3'(FIFO_TURN_CYCLES);

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         fifo_pend_q <= 1'b0;
         fifo_act_q <= 1'b0;
         fifo_rd_q <= 1'b0;
         fifo_cnt_q <= 3'h0;
         o_usb_read_n <= 1'b1;
         o_usb_write <= 1'b0;
         o_usb_data <= RESET_BYTE;
         o_usb_data_oe <= 1'b0;
      end else if (!fifo_pend_q) begin
         o_usb_data_oe <= sif.drive;
         o_usb_data <= data_q;
         if (fifo_need) begin
            fifo_pend_q <= 1'b1;
            fifo_rd_q <= (state_q <= ST_RX_TRL);
            fifo_cnt_q <= 3'h0;
         end else if (fifo_cnt_q != 3'(FIFO_TURN_CYCLES)) begin
            fifo_cnt_q <= fifo_cnt_q + 3'h1;
         end
      end else if (!fifo_act_q) begin
         // let the flag settle after the previous byte
         if (fifo_cnt_q != 3'(FIFO_TURN_CYCLES)) begin
            fifo_cnt_q <= fifo_cnt_q + 3'h1;
         end else if (fifo_rd_q ? !rxe_n_s : !txf_n_s) begin
            fifo_act_q <= 1'b1;
            fifo_cnt_q <= 3'h0;
            o_usb_read_n <= !fifo_rd_q;
            o_usb_write <= !fifo_rd_q;
            o_usb_data_oe <= !fifo_rd_q;
            o_usb_data <= tx_byte;
         end
      end else if (fifo_done) begin
         fifo_pend_q <= 1'b0;
         fifo_act_q <= 1'b0;
         fifo_cnt_q <= 3'h0;
         o_usb_read_n <= 1'b1;
         o_usb_write <= 1'b0;
         o_usb_data_oe <= 1'b0;
      end else begin
         fifo_cnt_q <= fifo_cnt_q + 3'h1;
      end
   end

   // ==========================================================
   // request and interrupt capture
   logic req_edge, uint_edge, pick_ext, pick_int, pick_err;

   assign req_edge = req_s && !req_prev_q;
   assign uint_edge = uint_s && !uint_prev_q;
   assign pick_err = (state_q == ST_IDLE) && rxe_n_s && err_pend_q;
   assign pick_ext = (state_q == ST_IDLE) && rxe_n_s && !err_pend_q &&
                     ext_pend_q;
   assign pick_int = (state_q == ST_IDLE) && rxe_n_s && !err_pend_q &&
                     !ext_pend_q && int_pend_q;

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         req_prev_q <= 1'b0;
         uint_prev_q <= 1'b0;
         ext_pend_q <= 1'b0;
         int_pend_q <= 1'b0;
      end else begin
         req_prev_q <= req_s;
         uint_prev_q <= uint_s;
         ext_pend_q <= (req_edge && ext_enable_q) ||
                       (ext_pend_q && !pick_ext);
         int_pend_q <= uint_edge || (int_pend_q && !pick_int);
      end
   end

   // ==========================================================
   // frame sequencer
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         state_q <= ST_IDLE;
         kind_q <= KIND_REPLY;
         count_q <= RESET_COUNT;
         idx_q <= RESET_COUNT;
         data_q <= RESET_BYTE;
         sub_q <= RESET_SUBADD;
         o_subadd <= RESET_SUBADD;
         wait_q <= 6'h00;
         is_rd_q <= 1'b0;
         busy_q <= 1'b0;
         ext_enable_q <= RESET_EXT_ENABLE;
         err_pend_q <= 1'b0;
         err_status_q <= RESET_BYTE;
         start_fault_q <= 1'b0;
         end_fault_q <= 1'b0;
      end else begin
         start_fault_q <= 1'b0;
         end_fault_q <= 1'b0;
         if (wait_q != 6'h3f) begin
            wait_q <= wait_q + 6'h01;
         end
         case (state_q)
            ST_IDLE: begin
               idx_q <= 8'h00;
               wait_q <= 6'h00;
               if (!rxe_n_s && fifo_quiet) begin
                  state_q <= ST_RX_HDR;
               end else if (pick_err) begin
                  err_pend_q <= 1'b0;
                  kind_q <= KIND_ERR;
                  data_q <= err_status_q;
                  state_q <= ST_TX_HDR;
               end else if (pick_ext) begin
                  state_q <= ST_EXT_WAIT;
               end else if (pick_int) begin
                  state_q <= ST_INT_WAIT;
               end
            end
            ST_RX_HDR: if (fifo_done) begin
               if (usb_s == HEADER_BYTE) begin
                  state_q <= ST_RX_C1;
               end else begin
                  start_fault_q <= 1'b1;
                  err_status_q <= 8'h00;
                  err_status_q[ERR_HEADER_BIT] <= 1'b1;
                  err_pend_q <= 1'b1;
                  state_q <= ST_IDLE;
               end
            end
            ST_RX_C1: if (fifo_done) begin
               count_q <= usb_s;
               state_q <= ST_RX_C2;
            end
            ST_RX_C2: if (fifo_done) begin
               is_rd_q <= usb_s[7];
               sub_q <= usb_s[6:0];
               o_subadd <= usb_s[6:0];
               state_q <= usb_s[7] ? ST_RX_TRL : ST_BUSY_PRE;
            end
            ST_BUSY_PRE: begin
               busy_q <= 1'b1;
               state_q <= is_rd_q ? ST_PER_RD : ST_RX_DATA;
            end
            ST_RX_DATA: if (fifo_done) begin
               data_q <= usb_s;
               state_q <= ST_PER_WR;
            end
            ST_PER_WR: if (sif.done || is_ver) begin
               if (is_ver) begin
                  ext_enable_q <= data_q[ENABLE_BIT];
               end
               idx_q <= idx_q + 8'h01;
               if (idx_q == count_q) begin
                  busy_q <= 1'b0;
                  state_q <= ST_RX_TRL;
               end else begin
                  state_q <= ST_RX_DATA;
               end
            end
            ST_RX_TRL: if (fifo_done) begin
               if (usb_s != TRAILER_BYTE) begin
                  end_fault_q <= 1'b1;
                  err_status_q <= 8'h00;
                  err_status_q[ERR_TRAILER_BIT] <= 1'b1;
                  err_pend_q <= 1'b1;
                  state_q <= ST_IDLE;
               end else begin
                  kind_q <= KIND_REPLY;
                  idx_q <= 8'h00;
                  state_q <= is_rd_q ? ST_TX_HDR : ST_IDLE;
               end
            end
            ST_TX_HDR: if (fifo_done) begin
               state_q <= ST_TX_C1;
            end
            ST_TX_C1: if (fifo_done) begin
               state_q <= ST_TX_C2;
            end
            ST_TX_C2: if (fifo_done) begin
               state_q <= (kind_q == KIND_EXT) ? ST_PER_RD :
                          (kind_q == KIND_REPLY) ? ST_BUSY_PRE : ST_TX_DATA;
            end
            ST_PER_RD: begin
               if (sif.start && kind_q == KIND_EXT) begin
                  wait_q <= 6'h00;
               end
               if (is_ver) begin
                  data_q <= INTERFACE_VERSION_BYTE;
                  state_q <= ST_TX_DATA;
               end else if (sif.done) begin
                  data_q <= sif.rdata;
                  state_q <= ST_TX_DATA;
               end
            end
            ST_TX_DATA: if (fifo_done) begin
               idx_q <= idx_q + 8'h01;
               if (kind_q == KIND_ERR || kind_q == KIND_USER ||
                   idx_q == count_q) begin
                  if (kind_q == KIND_REPLY) begin
                     busy_q <= 1'b0;
                  end
                  state_q <= ST_TX_TRL;
               end else begin
                  state_q <= ST_PER_RD;
               end
            end
            ST_TX_TRL: if (fifo_done) begin
               state_q <= (kind_q == KIND_EXT) ? ST_TAIL : ST_IDLE;
            end
            ST_TAIL: if (wait_q >= 6'(EXT_TAIL_CYCLES - 1)) begin
               busy_q <= 1'b0;
               state_q <= ST_IDLE;
            end
            ST_EXT_WAIT: begin
               busy_q <= 1'b1;
               o_subadd <= SUB_INTERRUPT;
               kind_q <= KIND_EXT;
               state_q <= ST_EXT_CNT;
            end
            ST_EXT_CNT: begin
               if (sif.start) begin
                  wait_q <= 6'h00;
               end
               if (sif.done) begin
                  count_q <= sif.rdata;
                  state_q <= ST_TX_HDR;
               end
            end
            ST_INT_WAIT: begin
               if (wait_q == 6'h00) begin
                  o_subadd <= SUB_INTERRUPT;
               end
               if (wait_q == 6'(INT_RD_DLY_CYCLES - 3)) begin
                  state_q <= ST_INT_RD;
               end
            end
            ST_INT_RD: if (sif.done) begin
               data_q <= sif.rdata;
               kind_q <= KIND_USER;
               state_q <= ST_TX_HDR;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // fault pulse outputs
   // busy leaves straight from its flop so it leads the strobe a full clock
   assign o_busy = busy_q;
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         end_cnt_q <= 2'h0;
         o_frame_start_fault <= 1'b0;
         o_frame_end_fault <= 1'b0;
      end else begin
         o_frame_start_fault <= start_fault_q;
         if (end_fault_q) begin
            end_cnt_q <= 2'(END_FAULT_CYCLES);
         end else if (end_cnt_q != 2'h0) begin
            end_cnt_q <= end_cnt_q - 2'h1;
         end
         o_frame_end_fault <= end_fault_q || end_cnt_q > 2'h1;
      end
   end
endmodule

// *** common/efp_pkg.sv ***
// constants shared by the framed fifo port and its helper modules
// assumes one interface clock; all delays are counted in its periods
package efp_pkg;
   localparam logic [7:0] HEADER_BYTE = 8'haa;
   localparam logic [7:0] TRAILER_BYTE = 8'h55;
   localparam logic [6:0] SUB_INTERRUPT = 7'h7f;
   localparam logic [6:0] OFS_INTERFACE_VERSION_BYTE = 7'h7e;
   localparam int ERR_HEADER_BIT = 0;
   localparam int ERR_TRAILER_BIT = 1;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] RESET_COUNT = 8'h00;
   localparam logic [6:0] RESET_SUBADD = 7'h00;
   localparam logic RESET_EXT_ENABLE = 1'b0;
   localparam int ENABLE_BIT = 0;
   // timings in interface clock periods
   localparam int STROBE_CYCLES = 4;
   localparam int FIFO_RD_CYCLES = 4;
   localparam int FIFO_WR_CYCLES = 2;
   localparam int FIFO_TURN_CYCLES = 3;
   localparam int EXT_GAP_CYCLES = 44;
   localparam int EXT_TAIL_CYCLES = 10;
   localparam int INT_RD_DLY_CYCLES = 20;
   localparam int END_FAULT_CYCLES = 2;
   localparam int SYNC_WIDTH = 22;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h00, ST_RX_HDR = 5'h01, ST_RX_C1 = 5'h02,
      ST_RX_C2 = 5'h03, ST_BUSY_PRE = 5'h04, ST_RX_DATA = 5'h05,
      ST_PER_WR = 5'h06, ST_RX_TRL = 5'h07, ST_TX_HDR = 5'h08,
      ST_TX_C1 = 5'h09, ST_TX_C2 = 5'h0a, ST_PER_RD = 5'h0b,
      ST_TX_DATA = 5'h0c, ST_TX_TRL = 5'h0d, ST_TAIL = 5'h0e,
      ST_EXT_WAIT = 5'h0f, ST_EXT_CNT = 5'h10, ST_INT_WAIT = 5'h11,
      ST_INT_RD = 5'h12
   } state_type;

   typedef enum logic [1:0] {
      KIND_REPLY = 2'h0, KIND_EXT = 2'h1, KIND_ERR = 2'h2, KIND_USER = 2'h3
   } kind_type;
endpackage

// *** common/strobe_if.sv ***
// request and answer between the frame sequencer and the strobe engine
// assumes both ends share one clock
`timescale 1ns/1ps
interface strobe_if;
   logic start;
   logic is_read;
   logic first;
   logic [7:0] wdata;
   logic done;
   logic [7:0] rdata;
   logic drive;
   modport engine(input start, input is_read, input first, input wdata,
                  output done, output rdata, output drive);
   modport user(output start, output is_read, output first, output wdata,
                input done, input rdata, input drive);
endinterface

// *** hw/pin_sync.sv ***
// two flip-flop synchroniser for a bundle of pin levels
// assumes each bit is a slow level or is held stable around its use
`timescale 1ns/1ps
module pin_sync import efp_pkg::*; #(
   parameter int WIDTH = SYNC_WIDTH
) (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         meta_q <= '0;
         o_sync <= '0;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule

// *** hw/periph_strobe.sv ***
// peripheral strobe engine: one write or read strobe per request
// assumes i_hold_low and i_data are already synchronised
`timescale 1ns/1ps
module periph_strobe import efp_pkg::*; (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_hold_low,
   input wire logic i_shared,
   input wire logic [7:0] i_data,
   output logic o_write_n,
   output logic o_read_n,
   output logic o_frame_first_strobe_n,
   output logic [7:0] o_user_data,
   output logic o_user_data_oe,
   strobe_if.engine eng
);
   logic act_q;
   logic [2:0] cnt_q;
   logic done_q;
   logic drive_q;
   logic [7:0] rdata_q;

   assign eng.done = done_q;
   assign eng.rdata = rdata_q;
   assign eng.drive = drive_q;

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         act_q <= 1'b0;
         cnt_q <= 3'h0;
         done_q <= 1'b0;
         drive_q <= 1'b0;
         rdata_q <= RESET_BYTE;
         o_write_n <= 1'b1;
         o_read_n <= 1'b1;
         o_frame_first_strobe_n <= 1'b1;
         o_user_data <= RESET_BYTE;
         o_user_data_oe <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (!act_q) begin
            if (eng.start) begin
               act_q <= 1'b1;
               cnt_q <= 3'h0;
               o_read_n <= !eng.is_read;
               o_write_n <= eng.is_read;
               o_frame_first_strobe_n <= !eng.first;
               o_user_data <= eng.wdata;
               o_user_data_oe <= !eng.is_read && !i_shared;
               drive_q <= !eng.is_read && i_shared;
            end
         end else begin
            if (cnt_q != 3'(STROBE_CYCLES - 1)) begin
               cnt_q <= cnt_q + 3'h1;
            end
            if (cnt_q == 3'(STROBE_CYCLES - 2)) begin
               o_frame_first_strobe_n <= 1'b1;
            end
            // stretched while the peripheral holds the line low
            if (cnt_q == 3'(STROBE_CYCLES - 1) && i_hold_low) begin
               act_q <= 1'b0;
               o_read_n <= 1'b1;
               o_write_n <= 1'b1;
               o_user_data_oe <= 1'b0;
               drive_q <= 1'b0;
               rdata_q <= i_data;
               done_q <= 1'b1;
            end
         end
      end
   end
endmodule

// *** sim/efp_monitor.sv ***
// checker for the framed fifo port, bound to its top module
// assumes one clock domain and the active-low asynchronous reset
`timescale 1ns/1ps
module efp_monitor import efp_pkg::*; (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic o_read_n,
   input wire logic o_write_n,
   input wire logic o_frame_first_strobe_n,
   input wire logic o_busy,
   input wire logic [6:0] o_subadd,
   input wire logic o_frame_start_fault,
   input wire logic o_frame_end_fault
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   // ==========
   // strobe shapes
   sequence s_rd_low; !o_read_n [*4]; endsequence
   sequence s_first_low; !o_frame_first_strobe_n [*3]; endsequence
   sequence s_end_two; o_frame_end_fault [*2]; endsequence
   property p_reset_idle;
      $rose(i_nrst) |-> !o_busy && o_read_n && o_write_n;
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("strobe or busy active after reset");
   property p_busy_wr;
      $fell(o_write_n) |-> $past(o_busy) && o_busy;
   endproperty
   a_busy_wr: assert property (p_busy_wr)
      else $error("write strobe without busy lead");
   property p_busy_rd; $fell(o_read_n) && o_busy |-> $past(o_busy); endproperty
   a_busy_rd: assert property (p_busy_rd)
      else $error("read strobe without busy lead");
   property p_user_sub;
      $fell(o_read_n) && !o_busy |-> o_subadd == SUB_INTERRUPT;
   endproperty
   a_user_sub: assert property (p_user_sub)
      else $error("status read off the interrupt offset");
   property p_rd_min; $fell(o_read_n) |-> s_rd_low; endproperty
   a_rd_min: assert property (p_rd_min)
      else $error("read strobe too short");
   property p_first;
      $fell(o_frame_first_strobe_n) |-> (!o_read_n || !o_write_n)
         ##0 s_first_low ##1 o_frame_first_strobe_n;
   endproperty
   a_first: assert property (p_first)
      else $error("first strobe marker misplaced");
   property p_sfault; $rose(o_frame_start_fault) |=> !o_frame_start_fault;
   endproperty
   a_sfault: assert property (p_sfault)
      else $error("start fault pulse not one clock");
   property p_efault;
      $rose(o_frame_end_fault) |-> s_end_two ##1 !o_frame_end_fault;
   endproperty
   a_efault: assert property (p_efault)
      else $error("end fault pulse not two clocks");
endmodule
bind extended_framed_fifo_port efp_monitor efp_monitor_inst (.i_clock,
   .i_nrst, .o_read_n, .o_write_n, .o_frame_first_strobe_n, .o_busy,
   .o_subadd, .o_frame_start_fault, .o_frame_end_fault);

// *** sim/periph_model.sv ***
// peripheral model: answers read strobes, count first, then data
// assumes separate buses, so its byte reaches the device on the user bus
`timescale 1ns/1ps
module periph_model import efp_pkg::*; (
   input wire logic i_read_n,
   input wire logic i_busy,
   input wire logic [6:0] i_subadd,
   output logic [7:0] o_data
);
   logic [7:0] reads_q = 8'h00;
   logic [7:0] last_q = 8'h00;
   logic [7:0] value;
   // ==========
   // answer byte
   always_comb begin
      if (!i_busy) value = (i_subadd == SUB_INTERRUPT) ? 8'hc3 : 8'h00;
      else value = (reads_q == 8'h00) ? 8'h01 : 8'h30 + reads_q;
   end
   // released bus shows the inverse of the last byte
   assign o_data = i_read_n ? ~last_q : value;
   always @(posedge i_read_n or negedge i_busy) begin
      if (!i_busy) reads_q <= 8'h00;
      else reads_q <= reads_q + 8'h01;
   end
   always @(posedge i_read_n) last_q <= value;
endmodule

// *** sim/tb.sv ***
// self-checking bench: fifo chip model inline, peripheral model beside
// assumes the design answers whole frames on the fifo side
`timescale 1ns/1ps
module tb import efp_pkg::*; ;
   localparam logic [7:0] VER = 8'h5a; // arbitrary value
   logic i_clock = 0, i_nrst = 0, i_rx_empty_n = 1, req = 0, intr = 0;
   logic [7:0] i_usb_data = 8'h00, user_data, o_usb_data, o_user_data;
   logic o_usb_data_oe, o_usb_read_n, o_usb_write, o_user_data_oe;
   logic o_write_n, o_read_n, o_frame_first_strobe_n, o_busy;
   logic o_frame_start_fault, o_frame_end_fault, rd_q = 1, wr_q = 0, hold = 1;
   logic [6:0] o_subadd;
   logic [7:0] rxq[$], txq[$];
   int fails = 0, checked = 0;
   always #25 i_clock = ~i_clock;
   extended_framed_fifo_port #(.INTERFACE_VERSION_BYTE(VER))
      extended_framed_fifo_port_inst (.i_clock, .i_nrst, .i_rx_empty_n,
      .i_tx_full_n(1'b0), .i_usb_data, .o_usb_data, .o_usb_data_oe,
      .o_usb_read_n, .o_usb_write, .i_user_data(user_data), .o_user_data,
      .o_user_data_oe, .o_subadd, .o_write_n, .o_read_n,
      .o_frame_first_strobe_n, .i_peripheral_hold_low(hold),
      .i_extended_read_request(req), .i_user_interrupt(intr),
      .i_shared_bus_select(1'b0), .o_busy, .o_frame_start_fault,
      .o_frame_end_fault);
   periph_model periph_model_inst (.i_read_n(o_read_n), .i_busy(o_busy),
      .i_subadd(o_subadd), .o_data(user_data));
   // ==========
   // fifo chip: pop on read strobe end, collect written bytes
   always @(posedge i_clock) begin
      #1;
      if (o_usb_read_n && !rd_q && rxq.size() > 0) void'(rxq.pop_front());
      rd_q = o_usb_read_n;
      if (o_usb_write && !wr_q) txq.push_back(o_usb_data);
      wr_q = o_usb_write;
      i_rx_empty_n = (rxq.size() == 0);
      i_usb_data = (rxq.size() > 0) ? rxq[0] : ~i_usb_data;
   end
   // ==========
   // shared tasks
   task check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task frame(input logic [7:0] e[$]);
      int k;
      for (k = 0; k < 4000 && txq.size() < e.size(); k++) @(posedge i_clock);
      if (txq.size() < e.size()) begin
         fails++;
         stop_test();
      end
      foreach (e[i]) check(txq[i], e[i]);
      txq.delete();
   endtask
   task automatic pulse(ref logic s);
      @(posedge i_clock);
      #1 s = 1;
      repeat (4) @(posedge i_clock);
      #1 s = 0;
   endtask
   // ==========
   // scenarios
   task t_version;
      rxq = '{8'haa, 8'h00, 8'hfe, 8'h55};
      frame('{8'haa, 8'h00, 8'hfe, VER, 8'h55});
      $display("version read done");
   endtask
   task t_errors;
      rxq = '{8'haa, 8'h00, 8'hfe, 8'h00};
      frame('{8'haa, 8'h00, 8'h7e, 8'h02, 8'h55});
      rxq = '{8'h11};
      frame('{8'haa, 8'h00, 8'h7e, 8'h01, 8'h55});
      $display("framing errors done");
   endtask
   task t_write;
      int k;
      rxq = '{8'haa, 8'h00, 8'h05, 8'h3c, 8'h55};
      for (k = 0; k < 400 && o_write_n; k++) begin
         @(posedge i_clock);
         #1;
      end
      if (o_write_n) begin
         fails++;
         stop_test();
      end
      check({o_busy, o_write_n, o_user_data_oe, 5'h00}, 8'ha0);
      check({o_frame_first_strobe_n, o_subadd}, 8'h05);
      check(o_user_data, 8'h3c);
      repeat (40) @(posedge i_clock);
      $display("host write done");
   endtask
   task t_ext;
      pulse(req);
      repeat (200) @(posedge i_clock);
      check(8'(txq.size()), 8'h00);
      rxq = '{8'haa, 8'h00, 8'h7e, 8'h01, 8'h55};
      repeat (200) @(posedge i_clock);
      pulse(req);
      frame('{8'haa, 8'h01, 8'hff, 8'h31, 8'h32, 8'h55});
      repeat (12) @(posedge i_clock);
      #1 check({7'h00, o_busy}, 8'h00);
      $display("extended read done");
   endtask
   task t_user;
      pulse(intr);
      hold = 0;
      repeat (40) @(posedge i_clock);
      #1 check({7'h00, o_read_n}, 8'h00);
      hold = 1;
      frame('{8'haa, 8'h00, 8'h7f, 8'hc3, 8'h55});
      $display("user interrupt done");
   endtask
   initial begin
      repeat (4) @(posedge i_clock);
      #1 i_nrst = 1;
      t_version();
      t_errors();
      t_write();
      t_ext();
      t_user();
      stop_test();
   end
endmodule
